//--- rtl/reset_cause_regs.vh
// Offsets, field positions, reset values and timing counts of the reset cause block
`ifndef RESET_CAUSE_REGS_VH
`define RESET_CAUSE_REGS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CAUSE_STATUS    12'h000
`define OFS_PROC_STATUS     12'h004
`define OFS_CONFIG          12'h008
`define OFS_RESUME_PC       12'h00C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_BROWNOUT_N      0
`define BIT_POWERON_N       1
`define BIT_POWERDOWN_N     3
`define BIT_TIMEOUT_N       4
`define BIT_CFG_XTAL        0
`define BIT_CFG_POWERUP_DELAY_TIMER_EN_N   1
`define BIT_CFG_BOD_EN      2
`define BIT_CFG_GIE         3

// ------------------------------------------------------------
// Reset values and vectors
// ------------------------------------------------------------
`define RST_PROC_STATUS     8'h18
`define RST_CONFIG          4'h1
`define VEC_RESET           13'h0000
`define VEC_IRQ             13'h0004

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define POWERUP_DELAY_TIMER_MS             72
`define CLK_HZ              100000000
`define POWERUP_DELAY_TIMER_CYCLES         ((`POWERUP_DELAY_TIMER_MS * (`CLK_HZ / 1000)))
`define OST_PERIODS         1024

`endif

//--- rtl/reset_cause_timeout.v
// Reset cause flags, start-up time-outs and reset vector selection
//
// Local design decisions: the APB slave port and the address map.
`include "reset_cause_regs.vh"

module reset_cause_timeout #(
    parameter CAUSE_BITS  = 2,
    parameter POWERUP_DELAY_TIMER_CYCLES = `POWERUP_DELAY_TIMER_CYCLES,
    parameter OST_PERIODS = `OST_PERIODS
) (
    // Clock and reset
    input  wire        I_CLK_SYS,
    input  wire        I_RST,
    // APB slave
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [11:0] I_PADDR,
    input  wire [31:0] I_PWDATA,
    output wire [31:0] O_PRDATA,
    output wire        O_PREADY,
    output wire        O_PSLVERR,
    // Reset and wake events, asynchronous pins
    input  wire        I_POWERON_EVT,
    input  wire        I_BROWNOUT_EVT,
    input  wire        I_MASTER_CLEAR_N,
    input  wire        I_WATCHDOG_EVT,
    input  wire        I_IRQ_WAKE,
    // Oscillator period ticks, asynchronous pin
    input  wire        I_OSC_CLK,
    // Core state
    input  wire        I_SLEEPING,
    input  wire [12:0] I_CORE_PC,
    // Outputs to the core
    output wire        O_CORE_RESET,
    output wire        O_REG_INIT,
    output wire        O_CORE_RUN,
    output wire [12:0] O_START_PC
);
    // ------------------------------------------------------------
    // Local definitions
    // ------------------------------------------------------------
    localparam [1:0] ST_RUN  = 2'd0;
    localparam [1:0] ST_POWERUP_DELAY_TIMER = 2'd1;
    localparam [1:0] ST_OST  = 2'd2;
    localparam [1:0] ST_HOLD = 2'd3;
    localparam       CW      = 24;
    // Counter width covers the full power-up delay at 100 MHz; a system clock
    // above 233 MHz needs a wider counter or the load value wraps

    // Implemented cause bit mask per variant
    function [1:0] cause_mask;
        input integer n;
        begin
            cause_mask = (n >= 2) ? 2'b11 : ((n == 1) ? 2'b10 : 2'b00);
        end
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg [5:0] sync1_ff;
    reg [5:0] sync2_ff;
    reg [5:0] prev_ff;
    wire [5:0] raw = {I_OSC_CLK, I_IRQ_WAKE, I_WATCHDOG_EVT, ~I_MASTER_CLEAR_N,
                      I_BROWNOUT_EVT, I_POWERON_EVT};

    // Two stages before any logic; prev only feeds the edge detect
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            sync1_ff <= 6'h00;
            sync2_ff <= 6'h00;
            prev_ff  <= 6'h00;
        end else begin
            sync1_ff <= raw;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    wire [5:0] rise     = sync2_ff & ~prev_ff;
    wire       ev_por   = rise[0];
    wire       ev_bor   = rise[1];
    wire       ev_master_clear_n  = rise[2];
    wire       ev_wdt   = rise[3];
    wire       ev_irq   = rise[4];
    wire       osc_tick = rise[5];
    wire       master_clear_n_low = sync2_ff[2];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [1:0]  cause_ff;
    reg        timeout_flag_n_ff;
    reg        powerdown_flag_n_ff;
    reg [3:0]  cfg_ff;
    reg [1:0]  state_ff;
    reg [1:0]  nxt_state;
    reg        init_ff;
    reg        wake_ff;
    reg        bor_pend_ff;
    reg [12:0] start_pc_ff;
    reg [31:0] prdata_ff;

    wire cfg_xtal   = cfg_ff[`BIT_CFG_XTAL];
    wire powerup_delay_timer_en_n  = cfg_ff[`BIT_CFG_POWERUP_DELAY_TIMER_EN_N];
    wire bod_en     = cfg_ff[`BIT_CFG_BOD_EN];
    wire global_irq_enable        = cfg_ff[`BIT_CFG_GIE];

    wire wr_en = I_PSEL && I_PENABLE && I_PWRITE;
    wire rd_en = I_PSEL && !I_PENABLE && !I_PWRITE;
    wire bor_hit = ev_bor && bod_en;            // Brown-out ignored when detection is off

    // ------------------------------------------------------------
    // Cause and status flags
    // ------------------------------------------------------------
    // Hardware events are applied after the bus write so they win
    // With brown-out detection off the brown-out cause is simply left as
    // written; software must ignore it in that configuration
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            cause_ff            <= 2'b00;
            timeout_flag_n_ff   <= 1'b1;
            powerdown_flag_n_ff <= 1'b1;
        end else begin
            if (wr_en && I_PADDR == `OFS_CAUSE_STATUS) begin
                cause_ff <= I_PWDATA[1:0] & cause_mask(CAUSE_BITS);
            end
            if (ev_por) begin
                cause_ff[`BIT_POWERON_N] <= 1'b0;
                timeout_flag_n_ff        <= 1'b1;
                powerdown_flag_n_ff      <= 1'b1;
            end else if (bor_hit) begin
                cause_ff[`BIT_BROWNOUT_N] <= 1'b0;
                timeout_flag_n_ff         <= 1'b1;
                powerdown_flag_n_ff       <= 1'b1;
            end else if (ev_wdt) begin
                timeout_flag_n_ff   <= 1'b0;
                powerdown_flag_n_ff <= ~I_SLEEPING;
            end else if ((ev_master_clear_n || ev_irq) && I_SLEEPING) begin
                timeout_flag_n_ff   <= 1'b1;
                powerdown_flag_n_ff <= 1'b0;
            end
            // Master clear while running leaves both flags untouched
        end
    end

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            cfg_ff <= `RST_CONFIG;
        end else if (wr_en && I_PADDR == `OFS_CONFIG) begin
            cfg_ff <= I_PWDATA[3:0];
        end
    end

    // ------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------
    wire powerup_delay_timer_busy;
    wire powerup_delay_timer_done;
    wire ost_busy;
    wire ost_done;
    reg  powerup_delay_timer_load;
    reg  ost_load;
    wire any_reset = ev_por || bor_hit || ev_master_clear_n || (ev_wdt && !I_SLEEPING);
    wire any_wake  = I_SLEEPING && ((ev_wdt) || ev_irq);
    // Power-up delay on power-on when enabled, always on brown-out
    wire need_powerup_delay_timer = bor_hit || (ev_por && !powerup_delay_timer_en_n);
    wire need_ost  = cfg_xtal && (ev_por || bor_hit || any_wake);

    // Any new event restarts the sequence from its first phase, so a
    // brown-out during the power-up delay reloads the full delay; the
    // trade-off is that a chattering supply can hold the core in reset
    always @* begin
        nxt_state = state_ff;
        powerup_delay_timer_load = 1'b0;
        ost_load  = 1'b0;
        if (any_reset || any_wake) begin
            if (need_powerup_delay_timer) begin
                nxt_state = ST_POWERUP_DELAY_TIMER;
                powerup_delay_timer_load = 1'b1;
            end else if (need_ost) begin
                nxt_state = ST_OST;
                ost_load  = 1'b1;
            end else begin
                nxt_state = ST_HOLD;
            end
        end else begin
            case (state_ff)
                ST_POWERUP_DELAY_TIMER: begin
                    if (powerup_delay_timer_done) begin
                        if (cfg_xtal) begin
                            nxt_state = ST_OST;
                            ost_load  = 1'b1;
                        end else begin
                            nxt_state = ST_HOLD;
                        end
                    end
                end
                ST_OST: begin
                    if (ost_done) begin
                        nxt_state = ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // Master clear held low keeps the core waiting
                    if (!master_clear_n_low) begin
                        nxt_state = ST_RUN;
                    end
                end
                default: begin
                    nxt_state = ST_RUN;
                end
            endcase
        end
    end

    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    startup_counter #(
        .WIDTH (CW)
    ) u_powerup_delay_timer (
        .i_clk   (I_CLK_SYS),
        .i_rst   (I_RST),
        .i_load  (powerup_delay_timer_load),
        .i_count (POWERUP_DELAY_TIMER_CYCLES[CW-1:0]),
        .i_tick  (1'b1),
        .o_busy  (powerup_delay_timer_busy),
        .o_done  (powerup_delay_timer_done)
    );

    // Ticks come from the synchronised oscillator, so periods are edges seen
    startup_counter #(
        .WIDTH (CW)
    ) u_ost (
        .i_clk   (I_CLK_SYS),
        .i_rst   (I_RST),
        .i_load  (ost_load),
        .i_count (OST_PERIODS[CW-1:0]),
        .i_tick  (osc_tick),
        .o_busy  (ost_busy),
        .o_done  (ost_done)
    );

    // ------------------------------------------------------------
    // Start address and register init
    // ------------------------------------------------------------
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            start_pc_ff <= `VEC_RESET;
            init_ff     <= 1'b1;
            wake_ff     <= 1'b0;
            bor_pend_ff <= 1'b0;
        end else if (any_reset) begin
            start_pc_ff <= `VEC_RESET;
            init_ff     <= 1'b1;
            wake_ff     <= 1'b0;
            bor_pend_ff <= bor_hit && !ev_por;
        end else if (any_wake) begin
            if (ev_irq && global_irq_enable) begin
                start_pc_ff <= `VEC_IRQ;
            end else begin
                start_pc_ff <= I_CORE_PC + 13'h0001;
            end
            init_ff <= 1'b0;
            wake_ff <= 1'b1;
        end else if (nxt_state == ST_RUN) begin
            init_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Processor status view: status bits other than 4 and 3 kept by core
    // ------------------------------------------------------------
    wire [7:0] proc_status = {3'b000, timeout_flag_n_ff, powerdown_flag_n_ff, 3'b000};

    // ------------------------------------------------------------
    // APB read data
    // ------------------------------------------------------------
    // Read data latched in setup so it is stable in the access phase
    always @(posedge I_CLK_SYS) begin
        if (I_RST) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_en) begin
            if (I_PADDR == `OFS_CAUSE_STATUS) begin
                prdata_ff <= {30'h0000_0000, cause_ff & cause_mask(CAUSE_BITS)};
            end else if (I_PADDR == `OFS_PROC_STATUS) begin
                prdata_ff <= {24'h00_0000, proc_status};
            end else if (I_PADDR == `OFS_CONFIG) begin
                prdata_ff <= {28'h000_0000, cfg_ff};
            end else if (I_PADDR == `OFS_RESUME_PC) begin
                prdata_ff <= {15'h0000, bor_pend_ff, wake_ff, ost_busy, powerup_delay_timer_busy, start_pc_ff};
            end else begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Only the four register offsets are mapped; anything else is refused
    wire mapped = (I_PADDR == `OFS_CAUSE_STATUS) || (I_PADDR == `OFS_PROC_STATUS) ||
                  (I_PADDR == `OFS_CONFIG) || (I_PADDR == `OFS_RESUME_PC);

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero wait states: every register answers in its first access cycle
    assign O_PRDATA     = prdata_ff;
    assign O_PREADY     = 1'b1;
    assign O_PSLVERR    = I_PSEL && I_PENABLE && !mapped;
    assign O_CORE_RESET = (state_ff != ST_RUN);
    assign O_REG_INIT   = init_ff && (state_ff != ST_RUN);
    assign O_CORE_RUN   = (state_ff == ST_RUN);
    assign O_START_PC   = start_pc_ff;
endmodule // reset_cause_timeout

//--- rtl/startup_counter.v
// Down counter that times one start-up phase in enable ticks
module startup_counter #(
    parameter WIDTH = 24
) (
    // Clock and reset
    input  wire             i_clk,
    input  wire             i_rst,
    // Control
    input  wire             i_load,
    input  wire [WIDTH-1:0] i_count,
    input  wire             i_tick,
    // Status
    output wire             o_busy,
    output wire             o_done
);
    reg [WIDTH-1:0] cnt_ff;
    reg             busy_ff;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Load wins over a tick so a restarted phase always runs in full
    always @(posedge i_clk) begin
        if (i_rst) begin
            cnt_ff  <= {WIDTH{1'b0}};
            busy_ff <= 1'b0;
        end else if (i_load) begin
            cnt_ff  <= i_count;
            busy_ff <= 1'b1;
        end else if (busy_ff && i_tick) begin
            cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
            if (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                busy_ff <= 1'b0;
            end
        end
    end

    assign o_busy = busy_ff;
    assign o_done = busy_ff && i_tick && (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule // startup_counter

//--- verif/reset_cause_timeout_assertions.sv
// Port-level checks for the reset cause and time-out block
module reset_cause_checker (
    // Clock and reset
    input wire        I_CLK_SYS,
    input wire        I_RST,
    // Register bus
    input wire        I_PSEL,
    input wire        I_PENABLE,
    input wire        I_PWRITE,
    input wire [31:0] O_PRDATA,
    input wire        O_PREADY,
    input wire        O_PSLVERR,
    // Events and core side
    input wire        I_POWERON_EVT,
    input wire        I_WATCHDOG_EVT,
    input wire        I_IRQ_WAKE,
    input wire        I_SLEEPING,
    input wire        O_CORE_RESET,
    input wire        O_REG_INIT,
    input wire        O_CORE_RUN,
    input wire [12:0] O_START_PC
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RST);
    // ------------------------------------------------------------
    // Bus and sequencer relations
    // ------------------------------------------------------------
    run_inverse_a: assert property (O_CORE_RUN == !O_CORE_RESET)
        else $error("run and reset outputs disagree");
    slverr_phase_a: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
        else $error("bus error outside access phase");
    slverr_zero_a: assert property (I_PSEL && I_PENABLE && !I_PWRITE && O_PSLVERR |-> O_PRDATA == 32'h0000_0000)
        else $error("refused read returned data");
    access_ready_a: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
        else $error("access phase not answered");
    after_reset_a: assert property ($past(I_RST) |-> !O_CORE_RESET && O_START_PC == 13'h0000)
        else $error("outputs wrong after block reset");
    // Power-on and watchdog resets must reload register reset values
    por_entry_a: assert property ($rose(I_POWERON_EVT) |-> ##[2:8] (O_CORE_RESET && O_REG_INIT))
        else $error("power-on did not enter reset");
    wdt_entry_a: assert property ($rose(I_WATCHDOG_EVT) && !I_SLEEPING |-> ##[2:8] (O_CORE_RESET && O_REG_INIT))
        else $error("watchdog did not reset");
    // A wake-up keeps register contents, so init must stay low
    wake_entry_a: assert property ($rose(I_IRQ_WAKE) && I_SLEEPING |-> ##[2:8] (O_CORE_RESET && !O_REG_INIT))
        else $error("interrupt wake handled as reset");
    reset_pc_a: assert property ($rose(O_CORE_RUN) && $past(O_REG_INIT) |-> O_START_PC == 13'h0000)
        else $error("reset did not start at zero");
    pc_stable_a: assert property (O_CORE_RUN && $past(O_CORE_RUN) |-> $stable(O_START_PC))
        else $error("start address moved while running");
    cov_por: cover property ($rose(I_POWERON_EVT) ##[2:8] O_CORE_RESET);
    cov_wake: cover property ($rose(O_CORE_RUN) && !$past(O_REG_INIT));
    cov_refuse: cover property (O_PSLVERR);
endmodule // reset_cause_checker

bind reset_cause_timeout reset_cause_checker chk (
    .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_POWERON_EVT(I_POWERON_EVT), .I_WATCHDOG_EVT(I_WATCHDOG_EVT), .I_IRQ_WAKE(I_IRQ_WAKE),
    .I_SLEEPING(I_SLEEPING), .O_CORE_RESET(O_CORE_RESET), .O_REG_INIT(O_REG_INIT),
    .O_CORE_RUN(O_CORE_RUN), .O_START_PC(O_START_PC)
);

//--- verif/tb_top.sv
// Self-checking bench for the reset cause and time-out block
`include "reset_cause_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [4:0]  evt = 5'h00;
    logic        slp = 1'b0;
    logic [12:0] core_pc = 13'h0000;
    logic [1:0]  div = 2'h0;
    logic        last_err;
    wire  [31:0] prdata;
    wire         pready, pslverr, core_reset, reg_init, core_run;
    wire  [12:0] start_pc;
    int          err_total = 0;
    int          compares = 0;

    // Short counts keep power-up runs to tens of cycles
    reset_cause_timeout #(.POWERUP_DELAY_TIMER_CYCLES(40), .OST_PERIODS(4)) uut (
        .I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_POWERON_EVT(evt[0]), .I_BROWNOUT_EVT(evt[1]),
        .I_MASTER_CLEAR_N(~evt[4]), .I_WATCHDOG_EVT(evt[2]), .I_IRQ_WAKE(evt[3]),
        .I_OSC_CLK(div[1]), .I_SLEEPING(slp), .I_CORE_PC(core_pc),
        .O_CORE_RESET(core_reset), .O_REG_INIT(reg_init), .O_CORE_RUN(core_run),
        .O_START_PC(start_pc)
    );

    initial forever #5 clk = ~clk;
    // Oscillator at a quarter of the system rate, well under the sync limit
    always @(posedge clk) div <= div + 2'h1;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; an idle edge first so strobes never change twice at once
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            end_of_test();
        end
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        check(r & m, e & m);
    endtask

    function automatic logic [12:0] exp_pc(int k, logic sl, logic global_irq_enable, logic [12:0] pc);
        if (k == 3 && global_irq_enable) return 13'h0004;
        if (sl && (k == 2 || k == 3)) return pc + 13'h0001;
        return 13'h0000;
    endfunction

    // Event k: 0 power-on, 1 brown-out, 2 watchdog, 3 irq wake, 4 master clear
    task automatic scen(input int k, input logic [3:0] cfg, input logic sl,
                        input logic [1:0] cause, input logic [7:0] proc, input int lo, hi);
        logic [12:0] pc;
        logic        init;
        int          len;
        len = 0;
        init = 1'b0;
        pc = 13'($urandom);
        wr(`OFS_CAUSE_STATUS, 32'h0000_0003);
        wr(`OFS_CONFIG, {28'h000_0000, cfg});
        @(posedge clk);
        slp <= sl;
        core_pc <= pc;
        evt[k] <= 1'b1;
        for (int i = 0; i < 300; i++) begin
            @(posedge clk);
            if (i == 4) evt <= 5'h00;
            if (core_reset === 1'b1) begin
                len++;
                init |= reg_init;
            end else if (len > 0) break;
        end
        if (core_reset !== 1'b0) begin
            err_total++;
            end_of_test();
        end
        check(len >= lo && len <= hi, 32'h0000_0001);
        if (len > 0) begin
            check(init, !(sl && (k == 2 || k == 3)));
            check(start_pc, exp_pc(k, sl, cfg[3], pc));
            rd_chk(`OFS_RESUME_PC, 32'h0000_1FFF, {19'h0, exp_pc(k, sl, cfg[3], pc)});
        end
        slp <= 1'b0;
        rd_chk(`OFS_CAUSE_STATUS, (k == 0) ? 32'h2 : 32'h3, {30'h0, cause});
        rd_chk(`OFS_PROC_STATUS, 32'h0000_0018, {24'h00_0000, proc});
        $display("event test %0d done", k);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        void'($urandom(32'h19eb));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`OFS_CAUSE_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_chk(`OFS_PROC_STATUS, 32'hFFFF_FFFF, 32'h0000_0018);
        rd_chk(`OFS_CONFIG, 32'hFFFF_FFFF, 32'h0000_0001);
        apb(1'b0, 12'h010, 32'h0000_0000, d);
        check(d, 32'h0000_0000);
        check(last_err, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            wr(`OFS_CAUSE_STATUS, d);
            rd_chk(`OFS_CAUSE_STATUS, 32'hFFFF_FFFF, d & 32'h0000_0003);
        end
        $display("register test done");
        scen(0, 4'h1, 1'b0, 2'b01, 8'h18, 52, 120);
        scen(0, 4'h3, 1'b0, 2'b01, 8'h18, 12, 39);
        scen(0, 4'h0, 1'b0, 2'b01, 8'h18, 39, 47);
        scen(0, 4'h2, 1'b0, 2'b01, 8'h18, 1, 7);
        scen(1, 4'h1, 1'b0, 2'b11, 8'h18, 0, 0);
        scen(1, 4'h7, 1'b0, 2'b10, 8'h18, 39, 120);
        scen(2, 4'h3, 1'b0, 2'b11, 8'h08, 1, 120);
        scen(4, 4'h3, 1'b0, 2'b11, 8'h08, 1, 120);
        scen(2, 4'h3, 1'b1, 2'b11, 8'h00, 12, 39);
        scen(3, 4'h3, 1'b1, 2'b11, 8'h10, 12, 39);
        scen(3, 4'hB, 1'b1, 2'b11, 8'h10, 12, 39);
        scen(4, 4'h3, 1'b1, 2'b11, 8'h10, 1, 120);
        end_of_test();
    end
endmodule // tb_top
